// >>> rtl/spc_pkg.sv
// Constants for the SCSI protocol controller: register map, fields, codes, timing.
// Assumes the register port carries full byte addresses.
package spc_pkg;
   localparam logic [31:0] A_DMA_CONTROL_STATUS = 32'h7840_0000;
   localparam logic [31:0] A_DMA_ADR = 32'h7840_0004;
   localparam logic [31:0] A_DMA_CNT = 32'h7840_0008;
   localparam logic [31:0] A_DMA_TST = 32'h7840_000C;
   localparam logic [31:0] A_TC_LO   = 32'h7880_0000;
   localparam logic [31:0] A_TC_MID  = 32'h7880_0004;
   localparam logic [31:0] A_FIFO    = 32'h7880_0008;
   localparam logic [31:0] A_CMD     = 32'h7880_000C;
   localparam logic [31:0] A_STAT    = 32'h7880_0010;
   localparam logic [31:0] A_ISTAT   = 32'h7880_0014;
   localparam logic [31:0] A_STEP    = 32'h7880_0018;
   localparam logic [31:0] A_FFLAG   = 32'h7880_001C;
   localparam logic [31:0] A_CFG1    = 32'h7880_0020;
   localparam logic [31:0] A_CCF     = 32'h7880_0024;
   localparam logic [31:0] A_TEST    = 32'h7880_0028;
   localparam logic [31:0] A_CFG2    = 32'h7880_002C;
   localparam logic [31:0] A_CFG3    = 32'h7880_0030;
   localparam logic [31:0] A_TC_HI   = 32'h7880_0038;
   // DMA control fields
   localparam int DMA_TOMEM_BIT = 8;
   localparam int DMA_BURST_LSB = 0;
   // Command fields and groups
   localparam int CMD_DMA_BIT = 7;
   localparam logic [2:0] G_IMM = 3'h0;
   localparam logic [2:0] G_INI = 3'h1;
   localparam logic [2:0] G_TGT = 3'h2;
   localparam logic [2:0] G_DIS = 3'h4;
   localparam logic [6:0] C_FLUSH = 7'h01;
   localparam logic [6:0] C_RSTC  = 7'h02;
   localparam logic [6:0] C_RSTB  = 7'h03;
   // Interrupt cause bits
   localparam int I_BRST = 7;
   localparam int I_ILL  = 6;
   localparam int I_DISC = 5;
   localparam int I_BSVC = 4;
   localparam int I_FC   = 3;
   localparam int I_RSEL = 2;
   localparam int I_SATN = 1;
   localparam int I_SEL  = 0;
   // Timing
   localparam int CLK_MHZ = 40;
   localparam logic [5:0] PER_MIN = 6'h05;
   localparam logic [5:0] PER_MAX = 6'h23;
   localparam int RST_US = 25;
   localparam logic [9:0] RST_CYC = 10'(RST_US * CLK_MHZ);
   localparam logic [2:0] SEQ_STEPS = 3'h4;
   localparam int SYNC_W = 16;
endpackage : spc_pkg

// >>> rtl/spc_top.sv
// SCSI protocol controller core with command queue, data FIFO and DMA staging.
// Assumes a simple one-cycle register port and SCSI pins from an external transceiver.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
// Function
// - Command port queues two pending commands.
// - Command bit 7 selects DMA data movement.
// - Bits 6:4 select one group; bits 6:0 form the code.
// - Invalid group for present state or unsupported code raises illegal command.
// - Immediate codes 0-3: nop, flush, reset core, reset bus; no interrupt.
// - Disconnected codes 0x40-0x47 run; all interrupt except enable selection.
// - Target codes 0x20-0x2C except 0x26 run; disconnect and abort DMA without interrupt.
// - Initiator 0x10,0x11,0x12,0x18 interrupt; 0x1A/0x1B drive attention silently.
// - Reading interrupt cause clears its flags.
// - Status shows interrupt, parity, terminal count, valid group.
// - Status bit 6 flags overwrites, direction conflict, sync phase change.
// - Status bits 2:0 show current bus phase.
// - Interrupt cause holds the eight event flags.
// - Config registers hold cable, parity, own id, queuing options.
// - Three count registers form one 24-bit counter.
// - 16-byte FIFO via data port; flags report its byte count.
// - Sync period sets byte spacing, six to thirty-two clocks.
// - Sequence step counts completed steps, holds on interrupt.
// - 64-byte staging FIFO; register accesses bypass it.
// - Bus-to-memory bytes collect until a full burst is possible.
module spc_top (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata_q,
   input  wire logic        scsi_rst_in,
   input  wire logic        scsi_sel_in,
   input  wire logic        scsi_resel_in,
   input  wire logic        scsi_atn_in,
   input  wire logic        scsi_perr_in,
   input  wire logic [2:0]  scsi_phase_in,
   input  wire logic [7:0]  scsi_din,
   output logic      [7:0]  scsi_dout_q,
   output logic             scsi_dstb_q,
   output logic             scsi_atn_q,
   output logic             scsi_rst_q,
   output logic      [31:0] mem_addr_q,
   output logic      [7:0]  mem_data_q,
   output logic             mem_we_q
);
   typedef enum logic [2:0] {S_IDLE = 3'b001, S_RUN = 3'b010, S_DONE = 3'b100} spc_state_t;
   // Pin inputs: three flops, accept when second and third agree
   logic [spc_pkg::SYNC_W-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q;
   assign pin_raw = {scsi_rst_in, scsi_sel_in, scsi_resel_in, scsi_atn_in, scsi_perr_in, scsi_phase_in, scsi_din};
   genvar gi;
   generate
      for (gi = 0; gi < spc_pkg::SYNC_W; gi++) begin : g_sync
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               s1_q[gi]  <= 1'b0;
               s2_q[gi]  <= 1'b0;
               s3_q[gi]  <= 1'b0;
               pin_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi]) pin_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate
   logic [4:0] pin_old_q;
   logic [2:0] ph_old_q;
   wire [2:0] phase = pin_q[10:8];
   wire [7:0] din = pin_q[7:0];
   wire rst_ev = pin_q[15] & ~pin_old_q[4];
   wire sel_ev = pin_q[14] & ~pin_old_q[3];
   wire rsl_ev = pin_q[13] & ~pin_old_q[2];
   wire ph_chg = phase != ph_old_q;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pin_old_q <= 5'h00;
         ph_old_q  <= 3'h0;
      end else begin
         pin_old_q <= pin_q[15:11];
         ph_old_q  <= phase;
      end
   end
   // Register decode; none of these touch the staging FIFO
   wire wr_cmd = wr && addr == spc_pkg::A_CMD;
   wire wr_fifo = wr && addr == spc_pkg::A_FIFO;
   wire rd_fifo = rd && addr == spc_pkg::A_FIFO;
   wire rd_ist = rd && addr == spc_pkg::A_ISTAT;
   logic [7:0] cfg1_q, cfg2_q, cfg3_q, ccf_q, test_q, tmo_q, off_q;
   logic [2:0] dest_q;
   logic [4:0] per_q;
   logic [31:0] dcsr_q, dtst_q;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {cfg1_q, cfg2_q, cfg3_q, ccf_q, test_q, tmo_q, off_q} <= '0;
         dest_q <= 3'h0;
         per_q  <= 5'h00;
         dcsr_q <= 32'h0000_0000;
         dtst_q <= 32'h0000_0000;
      end else if (wr) begin
         case (addr)
            spc_pkg::A_CFG1:    cfg1_q <= wdata[7:0];
            spc_pkg::A_CFG2:    cfg2_q <= wdata[7:0];
            spc_pkg::A_CFG3:    cfg3_q <= wdata[7:0];
            spc_pkg::A_CCF:     ccf_q  <= wdata[7:0];
            spc_pkg::A_TEST:    test_q <= wdata[7:0];
            spc_pkg::A_STAT:    dest_q <= wdata[2:0];
            spc_pkg::A_ISTAT:   tmo_q  <= wdata[7:0];
            spc_pkg::A_STEP:    per_q  <= wdata[4:0];
            spc_pkg::A_FFLAG:   off_q  <= wdata[7:0];
            spc_pkg::A_DMA_CONTROL_STATUS: dcsr_q <= wdata;
            spc_pkg::A_DMA_TST: dtst_q <= wdata;
            default: ;
         endcase
      end
   end
   // Command queue and decode
   logic [7:0] q0_q, q1_q, cmd_q;
   logic [1:0] qn_q;
   spc_state_t st_q;
   logic conn_q, tgt_q, srst;
   wire pop = st_q == S_IDLE && qn_q != 2'h0;
   wire [2:0] grp = q0_q[6:4];
   logic ok, irq, xfer, dirin, fixdir, valid_g;
   always_comb begin
      ok = 1'b0;
      irq = 1'b1;
      xfer = 1'b0;
      fixdir = 1'b1;
      dirin = 1'b0;
      case (grp)
         spc_pkg::G_IMM: valid_g = 1'b1;
         spc_pkg::G_DIS: valid_g = ~conn_q;
         spc_pkg::G_TGT: valid_g = tgt_q;
         spc_pkg::G_INI: valid_g = conn_q & ~tgt_q;
         default:        valid_g = 1'b0;
      endcase
      case (q0_q[6:0])
         7'h00, 7'h01, 7'h02, 7'h03: begin ok = 1'b1; irq = 1'b0; end
         7'h40, 7'h41, 7'h42, 7'h43, 7'h45, 7'h46, 7'h47: ok = 1'b1;
         7'h44: begin ok = 1'b1; irq = 1'b0; end
         7'h20, 7'h21, 7'h22: begin ok = 1'b1; xfer = 1'b1; end
         7'h23, 7'h24, 7'h25: ok = 1'b1;
         7'h27, 7'h2C: begin ok = 1'b1; irq = 1'b0; end
         7'h28, 7'h29, 7'h2A, 7'h2B: begin ok = 1'b1; xfer = 1'b1; dirin = 1'b1; end
         7'h10, 7'h18: begin ok = 1'b1; xfer = 1'b1; fixdir = 1'b0; end
         7'h11, 7'h12: ok = 1'b1;
         7'h1A, 7'h1B: begin ok = 1'b1; irq = 1'b0; end
         default: ;
      endcase
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q0_q <= 8'h00;
         q1_q <= 8'h00;
         qn_q <= 2'h0;
      end else if (srst) begin
         qn_q <= 2'h0;
      end else begin
         if (pop) begin
            q0_q <= q1_q;
            qn_q <= qn_q - 2'h1;
         end
         if (wr_cmd) begin
            if (qn_q == 2'h0 || (qn_q == 2'h1 && pop)) q0_q <= wdata[7:0];
            else q1_q <= wdata[7:0];
            if (!(qn_q == 2'h2 && !pop)) qn_q <= pop ? qn_q : qn_q + 2'h1;
         end
      end
   end
   wire ovr_cmd = wr_cmd && qn_q == 2'h2 && !pop;
   // Data FIFO (16 bytes)
   logic [7:0] ff_q [16];
   logic [3:0] fwp_q, frp_q;
   logic [4:0] fcnt_q;
   logic ex_push, ex_pop, flush;
   wire h_push = wr_fifo && fcnt_q != 5'h10;
   wire ovr_ff = wr_fifo && fcnt_q == 5'h10;
   wire push = h_push | ex_push;
   wire popf = (rd_fifo && fcnt_q != 5'h00) | ex_pop;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fwp_q  <= 4'h0;
         frp_q  <= 4'h0;
         fcnt_q <= 5'h00;
      end else if (srst || flush) begin
         fwp_q  <= 4'h0;
         frp_q  <= 4'h0;
         fcnt_q <= 5'h00;
      end else begin
         if (push) begin
            ff_q[fwp_q] <= ex_push ? din : wdata[7:0];
            fwp_q <= fwp_q + 4'h1;
         end
         if (popf) frp_q <= frp_q + 4'h1;
         fcnt_q <= fcnt_q + {4'h0, push} - {4'h0, popf};
      end
   end
   // Staging FIFO (64 bytes) and burst writer
   logic [7:0] sg_q [64];
   logic [5:0] swp_q, srp_q;
   logic [6:0] scnt_q, blen_q;
   logic [31:0] dadr_q;
   logic [23:0] dcnt_q;
   logic st_push;
   wire [6:0] burst = 7'h04 << dcsr_q[spc_pkg::DMA_BURST_LSB +: 2];
   wire bstart = blen_q == 7'h00 && scnt_q >= burst;
   wire bpop = blen_q != 7'h00;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         swp_q <= 6'h00;
         srp_q <= 6'h00;
         scnt_q <= 7'h00;
         blen_q <= 7'h00;
         dadr_q <= 32'h0000_0000;
         dcnt_q <= 24'h00_0000;
         mem_we_q <= 1'b0;
         mem_addr_q <= 32'h0000_0000;
         mem_data_q <= 8'h00;
      end else begin
         if (st_push) begin
            sg_q[swp_q] <= din;
            swp_q <= swp_q + 6'h01;
         end
         mem_we_q <= bpop;
         if (bpop) begin
            mem_addr_q <= dadr_q;
            mem_data_q <= sg_q[srp_q];
            srp_q <= srp_q + 6'h01;
            dadr_q <= dadr_q + 32'h1;
            dcnt_q <= dcnt_q - 24'h1;
         end
         blen_q <= bstart ? burst : (bpop ? blen_q - 7'h01 : blen_q);
         scnt_q <= scnt_q + {6'h00, st_push} - {6'h00, bpop};
         if (wr && addr == spc_pkg::A_DMA_ADR) dadr_q <= wdata;
         if (wr && addr == spc_pkg::A_DMA_CNT) dcnt_q <= wdata[23:0];
      end
   end
   // Sequencer
   logic [23:0] tc_q;
   logic [5:0] pcnt_q;
   logic [2:0] step_q;
   logic [9:0] rcnt_q;
   logic tcf_q, vgc_q, conflict;
   wire [5:0] spacing = per_q < spc_pkg::PER_MIN[4:0] ? spc_pkg::PER_MIN : {1'b0, per_q};
   wire [5:0] space_c = spacing > spc_pkg::PER_MAX ? spc_pkg::PER_MAX : spacing;
   wire is_dma = cmd_q[spc_pkg::CMD_DMA_BIT];
   logic c_xfer, c_irq, c_fix, c_din;
   wire tick = st_q == S_RUN && pcnt_q == 6'h00 && !rd_fifo && !wr_fifo && scnt_q != 7'h40;
   wire dir_in = c_fix ? c_din : phase[0];
   wire tc_last = c_xfer && is_dma && tc_q == 24'h00_0001;
   wire x_done = is_dma ? tc_last : (dir_in ? fcnt_q == 5'h0F : fcnt_q == 5'h01);
   // Only while running, else a finished command would keep flagging
   assign conflict = st_q == S_RUN && c_xfer && is_dma && (dcsr_q[spc_pkg::DMA_TOMEM_BIT] != dir_in);
   assign ex_push = tick && c_xfer && dir_in && !is_dma && !conflict && fcnt_q != 5'h10;
   assign ex_pop = tick && c_xfer && !dir_in && !conflict && fcnt_q != 5'h00;
   assign st_push = tick && c_xfer && dir_in && is_dma && !conflict;
   assign flush = pop && q0_q[6:0] == spc_pkg::C_FLUSH;
   assign srst = pop && q0_q[6:0] == spc_pkg::C_RSTC;
   wire illegal = pop && !(ok && valid_g);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= S_IDLE;
         cmd_q <= 8'h00;
         {c_xfer, c_irq, c_fix, c_din} <= 4'h0;
         pcnt_q <= 6'h00;
         step_q <= 3'h0;
         vgc_q <= 1'b0;
      end else begin
         case (st_q)
            S_IDLE: if (pop) begin
               cmd_q <= q0_q;
               {c_xfer, c_irq, c_fix, c_din} <= {xfer, irq, fixdir, dirin};
               vgc_q <= valid_g;
               step_q <= 3'h0;
               pcnt_q <= space_c;
               if (ok && valid_g && grp != spc_pkg::G_IMM) st_q <= S_RUN;
            end
            S_RUN: begin
               pcnt_q <= pcnt_q == 6'h00 ? (tick ? space_c : 6'h00) : pcnt_q - 6'h01;
               if (conflict) st_q <= S_DONE;
               else if (tick) begin
                  if (!c_xfer) step_q <= step_q + 3'h1;
                  if (c_xfer ? x_done : step_q == spc_pkg::SEQ_STEPS - 3'h1) st_q <= S_DONE;
               end
            end
            S_DONE: st_q <= S_IDLE;
            default: st_q <= S_IDLE;
         endcase
      end
   end
   wire done = st_q == S_DONE;
   wire [6:0] dc = cmd_q[6:0];
   wire to_disc = dc == 7'h23 || dc == 7'h24 || dc == 7'h27 || dc == 7'h11;
   wire to_conn = dc[6:4] == spc_pkg::G_DIS && dc[2:0] != 3'h4 && dc[2:0] != 3'h5;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         conn_q <= 1'b0;
         tgt_q <= 1'b0;
         scsi_atn_q <= 1'b0;
      end else if (srst || rst_ev) begin
         conn_q <= 1'b0;
         tgt_q <= 1'b0;
         scsi_atn_q <= 1'b0;
      end else begin
         if (sel_ev) tgt_q <= 1'b1;
         if (sel_ev) conn_q <= 1'b1;
         if (done && to_conn) conn_q <= 1'b1;
         if (done && to_disc) begin
            conn_q <= 1'b0;
            tgt_q <= 1'b0;
         end
         if (pop && ok && valid_g && q0_q[6:0] == 7'h1A) scsi_atn_q <= 1'b1;
         if (pop && ok && valid_g && q0_q[6:0] == 7'h1B) scsi_atn_q <= 1'b0;
      end
   end
   // Transfer counter; a sequencer decrement in the same cycle overrides a host load
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tc_q <= 24'h00_0000;
         tcf_q <= 1'b0;
      end else begin
         if (wr && addr == spc_pkg::A_TC_LO) tc_q[7:0] <= wdata[7:0];
         if (wr && addr == spc_pkg::A_TC_MID) tc_q[15:8] <= wdata[7:0];
         if (wr && addr == spc_pkg::A_TC_HI) tc_q[23:16] <= wdata[7:0];
         if (tick && c_xfer && is_dma && !conflict) tc_q <= tc_q - 24'h1;
         if (pop) tcf_q <= 1'b0;
         if (tick && tc_last && !conflict) tcf_q <= 1'b1;
      end
   end
   // Bus reset output and data strobe
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rcnt_q <= 10'h000;
         scsi_rst_q <= 1'b0;
         scsi_dout_q <= 8'h00;
         scsi_dstb_q <= 1'b0;
      end else begin
         if (pop && q0_q[6:0] == spc_pkg::C_RSTB) rcnt_q <= spc_pkg::RST_CYC;
         else if (rcnt_q != 10'h000) rcnt_q <= rcnt_q - 10'h001;
         scsi_rst_q <= rcnt_q != 10'h000;
         scsi_dstb_q <= ex_pop;
         if (ex_pop) scsi_dout_q <= ff_q[frp_q];
      end
   end
   // Sticky flags; a set in the clearing cycle survives
   logic [7:0] ist_q, ist_set;
   logic gross_q, par_q;
   always_comb begin
      ist_set = 8'h00;
      ist_set[spc_pkg::I_BRST] = rst_ev;
      ist_set[spc_pkg::I_ILL] = illegal;
      ist_set[spc_pkg::I_DISC] = done && to_disc && c_irq;
      ist_set[spc_pkg::I_BSVC] = conn_q && !tgt_q && st_q == S_IDLE && ph_chg;
      ist_set[spc_pkg::I_FC] = done && c_irq && !to_disc;
      ist_set[spc_pkg::I_RSEL] = rsl_ev;
      ist_set[spc_pkg::I_SATN] = sel_ev && pin_q[12];
      ist_set[spc_pkg::I_SEL] = sel_ev && !pin_q[12];
   end
   wire gross_set = ovr_ff || ovr_cmd || conflict || (st_q == S_RUN && c_xfer && !c_fix && off_q != 8'h00 && ph_chg);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ist_q <= 8'h00;
         gross_q <= 1'b0;
         par_q <= 1'b0;
      end else begin
         ist_q <= (srst ? 8'h00 : (rd_ist ? 8'h00 : ist_q)) | ist_set;
         gross_q <= (gross_q && !rd_ist && !srst) || gross_set;
         par_q <= (par_q && !rd_ist) || (pin_q[11] && cfg1_q[4]);
      end
   end
   wire [7:0] stat = {|ist_q, gross_q, par_q, tcf_q, vgc_q, phase};
   // Read port: data in the cycle after the strobe, zero otherwise
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) rdata_q <= 32'h0000_0000;
      else if (!rd) rdata_q <= 32'h0000_0000;
      else begin
         case (addr)
            spc_pkg::A_TC_LO:   rdata_q <= {24'h0, tc_q[7:0]};
            spc_pkg::A_TC_MID:  rdata_q <= {24'h0, tc_q[15:8]};
            spc_pkg::A_TC_HI:   rdata_q <= {24'h0, tc_q[23:16]};
            spc_pkg::A_FIFO:    rdata_q <= {24'h0, ff_q[frp_q]};
            spc_pkg::A_CMD:     rdata_q <= {24'h0, q0_q};
            spc_pkg::A_STAT:    rdata_q <= {24'h0, stat};
            spc_pkg::A_ISTAT:   rdata_q <= {24'h0, ist_q};
            spc_pkg::A_STEP:    rdata_q <= {29'h0, step_q};
            spc_pkg::A_FFLAG:   rdata_q <= {27'h0, fcnt_q};
            spc_pkg::A_CFG1:    rdata_q <= {24'h0, cfg1_q};
            spc_pkg::A_CFG2:    rdata_q <= {24'h0, cfg2_q};
            spc_pkg::A_CFG3:    rdata_q <= {24'h0, cfg3_q};
            spc_pkg::A_DMA_CONTROL_STATUS: rdata_q <= dcsr_q;
            spc_pkg::A_DMA_ADR: rdata_q <= dadr_q;
            spc_pkg::A_DMA_CNT: rdata_q <= {8'h0, dcnt_q};
            spc_pkg::A_DMA_TST: rdata_q <= dtst_q;
            default:            rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   // Checks
   cmd_overrun_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (wr_cmd && qn_q == 2'h2 && !pop) |=> gross_q) else $error("command overwrite not flagged");
   queue_depth_a: assert property (@(posedge mclk) disable iff (!reset_n)
      qn_q <= 2'h2) else $error("command queue over two");
   ist_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (rd_ist && ist_set == 8'h00 && !srst) |=> ist_q == 8'h00) else $error("cause not cleared");
   illegal_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
      illegal |=> ist_q[spc_pkg::I_ILL]) else $error("illegal command not flagged");
   imm_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (pop && grp == spc_pkg::G_IMM) |=> st_q == S_IDLE) else $error("immediate command ran");
   tc_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (tick && tc_last && !conflict) |=> (tcf_q && tc_q == 24'h0)) else $error("terminal count missed");
   phase_view_a: assert property (@(posedge mclk) disable iff (!reset_n)
      rd && addr == spc_pkg::A_STAT |=> rdata_q[2:0] == $past(phase)) else $error("phase not shown");
   fifo_bound_a: assert property (@(posedge mclk) disable iff (!reset_n)
      fcnt_q <= 5'h10 && scnt_q <= 7'h40) else $error("fifo count beyond depth");
   burst_len_a: assert property (@(posedge mclk) disable iff (!reset_n)
      bstart |=> (blen_q == $past(burst)) ##1 mem_we_q) else $error("burst started short");
   rst_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (pop && q0_q[6:0] == spc_pkg::C_RSTB) |=> ##1 scsi_rst_q) else $error("bus reset not driven");
endmodule : spc_top

// >>> verification/spc_bus_model.sv
// Far-side bus device: holds a fixed phase, answers bytes.
// Assumes one clock shared with the controller.
`timescale 1ns/100ps
module spc_bus_model #(parameter logic [2:0] PHASE = 3'h1) (
   input  wire logic       mclk,
   input  wire logic [7:0] dout,
   input  wire logic       dstb,
   output logic            rst_o,
   output logic            sel_o,
   output logic            resel_o,
   output logic            atn_o,
   output logic            perr_o,
   output logic      [2:0] phase_o,
   output logic      [7:0] din_o
);
   logic [7:0] last_q = 8'h00;
   assign rst_o   = 1'b0;
   assign sel_o   = 1'b0;
   assign resel_o = 1'b0;
   assign atn_o   = 1'b0;
   assign perr_o  = 1'b0;
   assign phase_o = PHASE;
   // Released line shows inverse, never a stale copy
   assign din_o = ~last_q;
   always @(posedge mclk) if (dstb) last_q <= dout;
endmodule : spc_bus_model

// >>> verification/spc_top_tb_top.sv
// Self-checking bench for the controller register port.
// Assumes one-cycle strobes and read data one cycle after the strobe.
`timescale 1ns/100ps
module spc_top_tb_top;
   logic mclk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [31:0] addr = 32'h0, wdata = 32'h0, rdata_q, got;
   logic s_rst, s_sel, s_resel, s_atn, s_perr, dstb, atn_q, rst_q, we;
   logic [2:0] s_phase;
   logic [7:0] s_din, dout, mdat;
   logic [31:0] madr;
   int fail_count = 0, checks = 0, cyc = 0, wcnt = 0, ocnt = 0;
   logic [31:0] wlast = 32'h0;
   logic [7:0] wdat = 8'h00;
   always #12.5 mclk = ~mclk;
   spc_top dut (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_q(rdata_q), .scsi_rst_in(s_rst), .scsi_sel_in(s_sel), .scsi_resel_in(s_resel),
      .scsi_atn_in(s_atn), .scsi_perr_in(s_perr), .scsi_phase_in(s_phase), .scsi_din(s_din),
      .scsi_dout_q(dout), .scsi_dstb_q(dstb), .scsi_atn_q(atn_q), .scsi_rst_q(rst_q),
      .mem_addr_q(madr), .mem_data_q(mdat), .mem_we_q(we));
   spc_bus_model #(.PHASE(3'h1)) far (.mclk(mclk), .dout(dout), .dstb(dstb), .rst_o(s_rst),
      .sel_o(s_sel), .resel_o(s_resel), .atn_o(s_atn), .perr_o(s_perr), .phase_o(s_phase),
      .din_o(s_din));
   task automatic final_report;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [31:0] a);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      got = rdata_q;
   endtask : rd_reg
   // Cuts a hang short
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         final_report();
      end
   end
   // Memory writes and outbound strobes, seen where they stand
   always @(posedge mclk) begin
      if (we) begin
         wcnt++;
         wlast = madr;
         wdat = mdat;
      end
      if (dstb) ocnt++;
   end
   logic [31:0] tca [3] = '{spc_pkg::A_TC_LO, spc_pkg::A_TC_MID, spc_pkg::A_TC_HI};
   initial begin
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (8) @(posedge mclk);
      rd_reg(spc_pkg::A_STAT);
      chk("phase", 32'h1, {29'h0, got[2:0]});
      wr_reg(spc_pkg::A_CFG1, 32'h17);
      rd_reg(spc_pkg::A_CFG1);
      chk("config_first", 32'h17, got);
      for (int i = 0; i < 3; i++) wr_reg(tca[i], 32'(8'h11 * (i + 1)));
      for (int i = 0; i < 3; i++) begin
         rd_reg(tca[i]);
         chk("transfer_count", 32'(8'h11 * (i + 1)), got);
      end
      rd_reg(32'h7880_0034);
      chk("unmapped", 32'h0, got);
      $display("test registers done");
      for (int i = 0; i < 3; i++) wr_reg(spc_pkg::A_FIFO, 32'hA5);
      rd_reg(spc_pkg::A_FFLAG);
      chk("fifo_count", 32'h3, {27'h0, got[4:0]});
      wr_reg(spc_pkg::A_CMD, {25'h0, spc_pkg::C_FLUSH});
      repeat (3) @(posedge mclk);
      rd_reg(spc_pkg::A_FFLAG);
      chk("flushed", 32'h0, {27'h0, got[4:0]});
      rd_reg(spc_pkg::A_STAT);
      chk("no_irq", 32'h0, {31'h0, got[7]});
      $display("test fifo done");
      // Target group while not selected is refused
      wr_reg(spc_pkg::A_CMD, 32'h20);
      repeat (3) @(posedge mclk);
      rd_reg(spc_pkg::A_STAT);
      chk("irq_pending", 32'h1, {31'h0, got[7]});
      rd_reg(spc_pkg::A_ISTAT);
      chk("illegal", 32'h1, {31'h0, got[spc_pkg::I_ILL]});
      rd_reg(spc_pkg::A_ISTAT);
      chk("cause_cleared", 32'h0, got);
      $display("test illegal done");
      wr_reg(spc_pkg::A_CCF, 32'h0);
      wr_reg(spc_pkg::A_STAT, 32'h3);
      wr_reg(spc_pkg::A_DMA_CONTROL_STATUS, 32'h1 << spc_pkg::DMA_TOMEM_BIT);
      wr_reg(spc_pkg::A_DMA_ADR, 32'h40);
      for (int i = 0; i < 3; i++) wr_reg(tca[i], (i == 0) ? 32'h4 : 32'h0);
      wr_reg(spc_pkg::A_CMD, 32'h41);
      repeat (40) @(posedge mclk);
      rd_reg(spc_pkg::A_STEP);
      chk("sequence_step", {29'h0, spc_pkg::SEQ_STEPS}, got);
      rd_reg(spc_pkg::A_STAT);
      chk("valid_group", 32'h1, {31'h0, got[3]});
      rd_reg(spc_pkg::A_ISTAT);
      chk("select_done", 32'h1, {31'h0, got[spc_pkg::I_FC]});
      wr_reg(spc_pkg::A_CMD, 32'h1A);
      wr_reg(spc_pkg::A_CMD, 32'h90);
      repeat (80) @(posedge mclk);
      chk("attention", 32'h1, {31'h0, atn_q});
      chk("mem_writes", 32'h4, 32'(wcnt));
      chk("mem_addr", 32'h43, wlast);
      chk("mem_data", 32'hFF, {24'h0, wdat});
      chk("out_strobes", 32'h0, 32'(ocnt));
      rd_reg(spc_pkg::A_STAT);
      chk("terminal_count", 32'h1, {31'h0, got[4]});
      rd_reg(spc_pkg::A_TC_LO);
      chk("count_zero", 32'h0, got);
      $display("test dma done");
      wr_reg(spc_pkg::A_CMD, {25'h0, spc_pkg::C_RSTB});
      repeat (3) @(posedge mclk);
      chk("bus_reset", 32'h1, {31'h0, rst_q});
      $display("test bus reset done");
      final_report();
   end
endmodule : spc_top_tb_top
